// File: common/ptp_stamp_pkg.sv
// Constants shared by the timestamp reporting ends.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ptp_stamp_pkg;
   localparam int unsigned STAMP_W = 128;
   localparam int unsigned NS_W = 32;
   localparam int unsigned SEC_W = 48;
   localparam int unsigned TAG_W = 16;
   localparam int unsigned CORR_W = 64;
   localparam int unsigned FRAC_W = 16;
   localparam int unsigned DATA_W = 32;
   // Field positions in the stamp words
   localparam int unsigned NS_LSB = 0;
   localparam int unsigned SEC_LSB = 32;
   localparam int unsigned TAG_LSB = 80;
   localparam int unsigned CORR_LSB = 0;
   // Nanosecond wrap point of the time-of-day timer
   localparam logic [31:0] NS_PER_SEC = 32'h3b9aca00;
   localparam logic [31:0] NS_MAX = 32'h3b9ac9ff;
   localparam logic [47:0] SEC_ONE = 48'h000000000001;
   localparam logic [63:0] CORR_STEP_DEFAULT = 64'h0000000000040000;
   // Stamp format selection
   typedef enum logic {
      FMT_TIME_OF_DAY = 1'b0,
      FMT_CORRECTION = 1'b1
   } stamp_fmt_t;
endpackage
`default_nettype wire

// File: common/ptp_stamp_if.sv
// Interface joining the MAC timestamp end and the consumer/timer end.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface ptp_stamp_if;
   logic [ptp_stamp_pkg::STAMP_W-1:0] tx_stamp_word;
   logic tx_stamp_valid;
   logic [ptp_stamp_pkg::STAMP_W-1:0] rx_stamp_word;
   logic rx_stamp_valid;
   logic [ptp_stamp_pkg::SEC_W-1:0] time_seconds_in;
   logic [ptp_stamp_pkg::NS_W-1:0] time_nanoseconds_in;
   logic [ptp_stamp_pkg::CORR_W-1:0] correction_timer_in;
   modport mac (
      output tx_stamp_word, tx_stamp_valid, rx_stamp_word, rx_stamp_valid,
      input time_seconds_in, time_nanoseconds_in, correction_timer_in
   );
   modport user (
      input tx_stamp_word, tx_stamp_valid, rx_stamp_word, rx_stamp_valid,
      output time_seconds_in, time_nanoseconds_in, correction_timer_in
   );
endinterface
`default_nettype wire

// File: hdl/ptp_stamp_mac.sv
// MAC end: captures the timer on frame events, reports stamps out of band.
// Assumes the timer arrives on this same clock and frame events are pulses.
// Assumes a frame start comes at least one cycle before its first word.
// Assumes no stamp reader ever needs to stall either stream.
`timescale 1ns/1ns
`default_nettype none
module ptp_stamp_mac (
   input wire logic clock, // 250 MHz clock
   input wire logic sys_rst, // Synchronous reset, active high
   ptp_stamp_if.mac link, // Stamps out, timer in
   input wire logic tx_frame_sent, // Pulse: frame start left the MAC
   input wire logic [ptp_stamp_pkg::TAG_W-1:0] tx_tag, // Tag of that frame
   input wire logic rx_data_valid, // Receive data word valid
   input wire logic rx_data_last, // Receive data last word
   input wire logic [ptp_stamp_pkg::DATA_W-1:0] rx_data_in, // Rx data
   input wire logic rx_sfd_seen, // Pulse: receive frame start
   input wire ptp_stamp_pkg::stamp_fmt_t rx_format, // Rx stamp format
   output logic [ptp_stamp_pkg::DATA_W-1:0] rx_data_out, // Delayed rx data
   output logic rx_data_out_valid, // Delayed rx valid
   output logic rx_data_out_last // Delayed rx last
);

   // Frame tracking: between frames, or past the first word of one
   typedef enum logic {
      RX_BETWEEN = 1'b0, // Next valid word opens a frame
      RX_INSIDE = 1'b1 // Later words of an open frame
   } rx_track_t;

   // Receive side bookkeeping and the packed words to load
   rx_track_t rx_track; // Where the receive stream stands
   rx_track_t next_rx_track; // Its value after this edge
   logic rx_first_word; // This word opens a frame
   logic rx_armed; // Start seen, stamp not yet released
   logic [ptp_stamp_pkg::STAMP_W-1:0] rx_capture; // Time at frame start
   logic [ptp_stamp_pkg::STAMP_W-1:0] tx_packed; // Tx word to load
   logic [ptp_stamp_pkg::STAMP_W-1:0] rx_tod_packed; // Rx time-of-day
   logic [ptp_stamp_pkg::STAMP_W-1:0] rx_corr_packed; // Rx correction

   // Transmit word from the timer as it stands now; top bits reserved
   always_comb begin
      tx_packed = '0;
      tx_packed[ptp_stamp_pkg::NS_LSB +: ptp_stamp_pkg::NS_W] =
         link.time_nanoseconds_in;
      tx_packed[ptp_stamp_pkg::SEC_LSB +: ptp_stamp_pkg::SEC_W] =
         link.time_seconds_in;
      tx_packed[ptp_stamp_pkg::TAG_LSB +: ptp_stamp_pkg::TAG_W] =
         tx_tag;
   end

   // Receive time-of-day word; bits above the seconds stay zero
   always_comb begin
      rx_tod_packed = '0;
      rx_tod_packed[ptp_stamp_pkg::NS_LSB +: ptp_stamp_pkg::NS_W] =
         link.time_nanoseconds_in;
      rx_tod_packed[ptp_stamp_pkg::SEC_LSB +: ptp_stamp_pkg::SEC_W] =
         link.time_seconds_in;
   end

   // Correction word taken whole, so the fraction below bit 16
   // keeps its binary weight untouched
   always_comb begin
      rx_corr_packed = '0;
      rx_corr_packed[ptp_stamp_pkg::CORR_LSB +: ptp_stamp_pkg::CORR_W] =
         link.correction_timer_in;
   end

   // One valid per frame event; with no ready input nothing can
   // stall it, so back-to-back frames give back-to-back pulses
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link.tx_stamp_valid <= 1'b0;
      end else begin
         link.tx_stamp_valid <= tx_frame_sent;
      end
   end

   // Word held until the next frame, so late readers still see it
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link.tx_stamp_word <= '0;
      end else if (tx_frame_sent) begin
         link.tx_stamp_word <= tx_packed;
      end
   end

   // Only a word outside an open frame may carry a stamp
   assign rx_first_word = rx_data_valid && (rx_track == RX_BETWEEN);

   // Frame boundaries follow the valid and last levels only
   always_comb begin
      next_rx_track = rx_track;
      case (rx_track)
         RX_BETWEEN: begin
            if (rx_data_valid && !rx_data_last) begin
               next_rx_track = RX_INSIDE;
            end
         end
         RX_INSIDE: begin
            if (rx_data_valid && rx_data_last) begin
               next_rx_track = RX_BETWEEN;
            end
         end
         default: begin
            // Unreachable with one bit, kept for safety
            next_rx_track = RX_BETWEEN;
         end
      endcase
   end

   // Frame tracking state; a last word returns it to between frames
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_track <= RX_BETWEEN;
      end else begin
         rx_track <= next_rx_track;
      end
   end

   // A start wins over a release in the same cycle, so a start that
   // rides on a one-word frame still arms the following frame
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_armed <= 1'b0;
      end else if (rx_sfd_seen) begin
         rx_armed <= 1'b1;
      end else if (rx_first_word) begin
         rx_armed <= 1'b0;
      end
   end

   // Timer taken at frame start in the format chosen then; a second
   // start before the first word simply takes a newer time
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_capture <= '0;
      end else if (rx_sfd_seen) begin
         if (rx_format == ptp_stamp_pkg::FMT_CORRECTION) begin
            rx_capture <= rx_corr_packed;
         end else begin
            rx_capture <= rx_tod_packed;
         end
      end
   end

   // Data delayed one cycle to line up with the registered stamp;
   // costs a cycle of latency but keeps both on flip-flops
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_data_out <= '0;
      end else begin
         rx_data_out <= rx_data_in;
      end
   end

   // Delayed word valid
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_data_out_valid <= 1'b0;
      end else begin
         rx_data_out_valid <= rx_data_valid;
      end
   end

   // Delayed last, only on a real word
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_data_out_last <= 1'b0;
      end else begin
         rx_data_out_last <= rx_data_valid && rx_data_last;
      end
   end

   // Stamp released with the first word; a frame whose start was
   // missed gets none rather than a stale time
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link.rx_stamp_valid <= 1'b0;
      end else begin
         link.rx_stamp_valid <= rx_first_word
            && rx_armed;
      end
   end

   // Stamp word loaded on every first word, armed or not; it travels out of band, beside
   // the data rather than inside it
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link.rx_stamp_word <= '0;
      end else if (rx_first_word) begin
         link.rx_stamp_word <= rx_capture;
      end
   end
endmodule // ptp_stamp_mac
`default_nettype wire

// File: hdl/ptp_stamp_user.sv
// Consumer end: runs the system timer and latches delivered stamps.
// Assumes the MAC end shares this clock; no back-pressure exists.
`timescale 1ns/1ns
`default_nettype none
module ptp_stamp_user #(
   parameter logic [31:0] NS_STEP = 32'h00000004, // Ns added per clock
   parameter logic [63:0] CORR_STEP = ptp_stamp_pkg::CORR_STEP_DEFAULT
) (
   input wire logic clock, // 250 MHz clock, also the timer clock
   input wire logic sys_rst, // Synchronous reset, active high
   ptp_stamp_if.user link, // Stamps in, timer out
   output logic [ptp_stamp_pkg::STAMP_W-1:0] last_tx_stamp, // Held tx
   output logic [ptp_stamp_pkg::STAMP_W-1:0] last_rx_stamp, // Held rx
   output logic tx_stamp_seen, // Pulse: tx stamp latched
   output logic rx_stamp_seen // Pulse: rx stamp latched
);
   logic [ptp_stamp_pkg::NS_W:0] ns_sum;

   assign ns_sum = {1'b0, link.time_nanoseconds_in} + {1'b0, NS_STEP};

   // Time-of-day timer; wrap must land exactly on zero range
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link.time_nanoseconds_in <= '0;
         link.time_seconds_in <= '0;
      end else if (ns_sum > {1'b0, ptp_stamp_pkg::NS_MAX}) begin
         link.time_nanoseconds_in <= 32'(ns_sum
            - {1'b0, ptp_stamp_pkg::NS_PER_SEC});
         link.time_seconds_in <= link.time_seconds_in
            + ptp_stamp_pkg::SEC_ONE;
      end else begin
         link.time_nanoseconds_in <= ns_sum[ptp_stamp_pkg::NS_W-1:0];
      end
   end

   // Correction timer: whole ns above a 16-bit binary fraction
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link.correction_timer_in <= '0;
      end else begin
         link.correction_timer_in <= link.correction_timer_in
            + CORR_STEP;
      end
   end

   // Stamps latched on the valid cycle; upper rx half is ignored
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         last_tx_stamp <= '0;
         last_rx_stamp <= '0;
         tx_stamp_seen <= 1'b0;
         rx_stamp_seen <= 1'b0;
      end else begin
         tx_stamp_seen <= link.tx_stamp_valid;
         rx_stamp_seen <= link.rx_stamp_valid;
         if (link.tx_stamp_valid) begin
            last_tx_stamp <= link.tx_stamp_word;
         end
         if (link.rx_stamp_valid) begin
            last_rx_stamp <= {{ptp_stamp_pkg::CORR_W{1'b0}},
               link.rx_stamp_word[ptp_stamp_pkg::CORR_W-1:0]};
         end
      end
   end
endmodule // ptp_stamp_user
`default_nettype wire

// File: dv/ptp_stamp_assertions.sv
// Checker of the signals between the timestamp ends.
// Assumes one clock and the timer steps of the user end.
`timescale 1ns/1ns
`default_nettype none
module ptp_stamp_assertions #(
   parameter logic [31:0] NS_STEP = 32'h00000004, // Ns added per clock
   parameter logic [63:0] CORR_STEP = 64'h0000000000040000 // Timer step
) (
   input wire logic clock, // Clock
   input wire logic sys_rst, // Reset, active high
   input wire logic [127:0] tx_stamp_word, // Tx stamp
   input wire logic tx_stamp_valid, // Tx stamp valid
   input wire logic [127:0] rx_stamp_word, // Rx stamp
   input wire logic rx_stamp_valid, // Rx stamp valid
   input wire logic [47:0] time_seconds_in, // Timer seconds
   input wire logic [31:0] time_nanoseconds_in, // Timer nanoseconds
   input wire logic [63:0] correction_timer_in // Correction timer
);
   logic [31:0] ns_sum;
   logic [1:0] up;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Next nanoseconds before folding
   assign ns_sum = time_nanoseconds_in + NS_STEP;
   // Timer steps are judged only two edges after reset, past values settled
   always_ff @(posedge clock) begin
      up <= sys_rst ? 2'b00 : {up[0], 1'b1};
   end
   a_ns_range: assert property (
      time_nanoseconds_in <= ptp_stamp_pkg::NS_MAX)
      else $error("nanoseconds beyond wrap point");
   a_ns_advance: assert property (
      up[1] |-> time_nanoseconds_in ==
      ($past(ns_sum) >= ptp_stamp_pkg::NS_PER_SEC ?
      $past(ns_sum) - ptp_stamp_pkg::NS_PER_SEC : $past(ns_sum)))
      else $error("nanoseconds stepped wrongly");
   a_sec_on_wrap: assert property (
      up[1] && time_nanoseconds_in <
      $past(time_nanoseconds_in) |-> time_seconds_in ==
      $past(time_seconds_in) + 48'h000000000001)
      else $error("seconds not advanced on wrap");
   a_sec_steady: assert property (
      up[1] && time_nanoseconds_in >=
      $past(time_nanoseconds_in) |-> $stable(time_seconds_in))
      else $error("seconds moved without wrap");
   a_corr_step: assert property (
      up[1] |-> correction_timer_in -
      $past(correction_timer_in) == CORR_STEP)
      else $error("correction timer step wrong");
   a_tx_time: assert property (
      tx_stamp_valid |-> tx_stamp_word[79:0] ==
      {$past(time_seconds_in), $past(time_nanoseconds_in)})
      else $error("tx stamp time fields wrong");
   a_tx_reserved: assert property (
      tx_stamp_valid |-> tx_stamp_word[127:96] == 32'h00000000)
      else $error("tx stamp reserved bits set");
   a_rx_reserved: assert property (
      rx_stamp_valid |-> rx_stamp_word[127:80] == 48'h000000000000)
      else $error("rx stamp reserved bits set");
   c_tx: cover property (tx_stamp_valid);
   c_rx: cover property (rx_stamp_valid);
   c_tx_pair: cover property (tx_stamp_valid [*2]);
   c_wrap: cover property (up[1] &&
      time_nanoseconds_in < $past(time_nanoseconds_in));
endmodule // ptp_stamp_assertions
`default_nettype wire

// File: dv/ptp_stamp_tb.sv
// Self-checking bench joining both timestamp ends.
// Assumes the timer inputs are stable between clock edges.
`timescale 1ns/1ns
`default_nettype none
module ptp_stamp_tb;
   typedef struct packed {
      logic [15:0] tag;
      logic fmt;
      logic [31:0] data;
   } row_t;
   // Big step so the nanoseconds wrap every ten clocks
   localparam logic [31:0] STEP = 32'h05f5e100;
   row_t rows [4] = '{'{16'h0001, 1'b0, 32'h0000a5a5},
      '{16'hffff, 1'b1, 32'h5a5a0000}, '{16'h8000, 1'b0, 32'h00000001},
      '{16'h1234, 1'b1, 32'hffffffff}};
   logic clock = 1'b0, sys_rst = 1'b1;
   logic tx_frame_sent = 1'b0, rx_sfd_seen = 1'b0;
   logic rx_data_valid = 1'b0, rx_data_last = 1'b0;
   logic [15:0] tx_tag = 16'h0000;
   logic [31:0] rx_data_in = 32'h00000000, rx_data_out;
   ptp_stamp_pkg::stamp_fmt_t rx_format = ptp_stamp_pkg::FMT_TIME_OF_DAY;
   logic rx_data_out_valid, rx_data_out_last, tx_stamp_seen, rx_stamp_seen;
   logic [127:0] last_tx_stamp, last_rx_stamp, exp_tx, exp_rx;
   int fail_count = 0, n_compared = 0;
   ptp_stamp_if ptp_stamp_if_i ();
   ptp_stamp_mac ptp_stamp_mac_i (.clock, .sys_rst, .link(ptp_stamp_if_i),
      .tx_frame_sent, .tx_tag, .rx_data_valid, .rx_data_last, .rx_data_in,
      .rx_sfd_seen, .rx_format, .rx_data_out, .rx_data_out_valid,
      .rx_data_out_last);
   ptp_stamp_user #(.NS_STEP(STEP)) ptp_stamp_user_i (.clock, .sys_rst,
      .link(ptp_stamp_if_i), .last_tx_stamp, .last_rx_stamp, .tx_stamp_seen,
      .rx_stamp_seen);
   ptp_stamp_assertions #(.NS_STEP(STEP)) ptp_stamp_assertions_i (.clock,
      .sys_rst, .tx_stamp_word(ptp_stamp_if_i.tx_stamp_word),
      .tx_stamp_valid(ptp_stamp_if_i.tx_stamp_valid),
      .rx_stamp_word(ptp_stamp_if_i.rx_stamp_word),
      .rx_stamp_valid(ptp_stamp_if_i.rx_stamp_valid),
      .time_seconds_in(ptp_stamp_if_i.time_seconds_in),
      .time_nanoseconds_in(ptp_stamp_if_i.time_nanoseconds_in),
      .correction_timer_in(ptp_stamp_if_i.correction_timer_in));
   // Compare and count
   task automatic chk(input string what, input logic [127:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Inputs move 1 ns after the edge, never on it
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   // Timer value that the next edge captures
   function automatic logic [79:0] now_tod;
      return {ptp_stamp_if_i.time_seconds_in,
         ptp_stamp_if_i.time_nanoseconds_in};
   endfunction
   // One tx frame and one single-word rx frame started together
   task automatic frame(input row_t r);
      {tx_frame_sent, rx_sfd_seen, tx_tag} = {2'b11, r.tag};
      rx_format = ptp_stamp_pkg::stamp_fmt_t'(r.fmt);
      exp_tx = {32'h00000000, r.tag, now_tod()};
      exp_rx = r.fmt ? {64'h0, ptp_stamp_if_i.correction_timer_in}
         : {48'h0, now_tod()};
      tick;
      chk("tx valid", 128'h1, ptp_stamp_if_i.tx_stamp_valid);
      chk("tx word", exp_tx, ptp_stamp_if_i.tx_stamp_word);
      {tx_frame_sent, rx_sfd_seen, rx_data_valid, rx_data_last} = 4'b0011;
      rx_data_in = r.data;
      tick;
      {rx_data_valid, rx_data_last} = 2'b00;
      chk("rx valid", 128'h1, ptp_stamp_if_i.rx_stamp_valid);
      chk("rx word", exp_rx, ptp_stamp_if_i.rx_stamp_word);
      chk("rx data", {96'h0, r.data}, {96'h0, rx_data_out});
      chk("rx out valid", 128'h1, rx_data_out_valid);
      chk("rx out last", 128'h1, rx_data_out_last);
      chk("tx pulse", 128'h0, ptp_stamp_if_i.tx_stamp_valid);
      chk("tx seen", 128'h1, tx_stamp_seen);
      tick;
      chk("rx pulse", 128'h0, ptp_stamp_if_i.rx_stamp_valid);
      chk("rx seen", 128'h1, rx_stamp_seen);
      chk("held tx", exp_tx, last_tx_stamp);
      chk("held rx", {64'h0, exp_rx[63:0]}, last_rx_stamp);
   endtask
   initial begin
      forever #2 clock = ~clock;
   end
   // Cut a hang short
   initial begin
      repeat (400) @(posedge clock);
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clock);
      #1 sys_rst = 1'b0;
      chk("reset tx", 128'h0, ptp_stamp_if_i.tx_stamp_word);
      chk("reset rx valid", 128'h0, ptp_stamp_if_i.rx_stamp_valid);
      foreach (rows[i]) frame(rows[i]);
      // Back-to-back tx frames, no stalls
      {tx_frame_sent, tx_tag} = {1'b1, 16'hbeef};
      exp_tx = {32'h0, 16'hbeef, now_tod()};
      tick;
      tx_tag = 16'h0f0f;
      exp_rx = {32'h0, 16'h0f0f, now_tod()};
      chk("tx first", exp_tx, ptp_stamp_if_i.tx_stamp_word);
      tick;
      tx_frame_sent = 1'b0;
      chk("tx second", exp_rx, ptp_stamp_if_i.tx_stamp_word);
      chk("tx second valid", 128'h1, ptp_stamp_if_i.tx_stamp_valid);
      // Rx word with no frame start gives no stamp
      {rx_data_valid, rx_data_last} = 2'b11;
      tick;
      {rx_data_valid, rx_data_last} = 2'b00;
      chk("tx ended", 128'h0, ptp_stamp_if_i.tx_stamp_valid);
      chk("rx no start", 128'h0, ptp_stamp_if_i.rx_stamp_valid);
      chk("rx unstamped", 128'h1, rx_data_out_valid);
      // Reset between frame start and first word drops the stamp
      rx_sfd_seen = 1'b1;
      tick;
      {rx_sfd_seen, sys_rst} = 2'b01;
      tick;
      sys_rst = 1'b0;
      chk("mid reset tx", 128'h0, ptp_stamp_if_i.tx_stamp_word);
      {rx_data_valid, rx_data_last} = 2'b11;
      tick;
      {rx_data_valid, rx_data_last} = 2'b00;
      chk("rx after reset", 128'h0, ptp_stamp_if_i.rx_stamp_valid);
      report_and_stop();
   end
endmodule // ptp_stamp_tb
`default_nettype wire
